// ---- rtl/plcr_pkg.sv ----
// Package: offsets, field positions, reset values and carrier types of the PHY link register view
package plcr_pkg;

    // ============================================================
    // Register indices and byte addresses
    localparam int unsigned    PLCR_ADDR_W          = 12;
    localparam logic [11:0]    PLCR_IDX_PARTNER     = 12'h056;
    localparam logic [11:0]    PLCR_IDX_CONTROL     = 12'h058;
    localparam logic [11:0]    PLCR_ADDR_PARTNER    = 12'(PLCR_IDX_PARTNER << 2);
    localparam logic [11:0]    PLCR_ADDR_CONTROL    = 12'(PLCR_IDX_CONTROL << 2);

    // ============================================================
    // Partner ability word fields
    localparam int unsigned    PLCR_PA_PAUSE        = 10;
    localparam int unsigned    PLCR_PA_100FD        = 8;
    localparam int unsigned    PLCR_PA_100HD        = 7;
    localparam int unsigned    PLCR_PA_BIT6         = 6;
    localparam int unsigned    PLCR_PA_10HD         = 5;
    localparam logic [4:0]     PLCR_PA_LOW_VALUE    = 5'h01;
    localparam logic [4:0]     PLCR_STATUS_RESET    = 5'h00;

    // ============================================================
    // Port 2 basic control word fields
    localparam int unsigned    PLCR_BC_LOOPBACK     = 14;
    localparam int unsigned    PLCR_BC_FORCE_100    = 13;
    localparam int unsigned    PLCR_BC_AN_ENABLE    = 12;
    localparam int unsigned    PLCR_BC_POWER_DOWN   = 11;
    localparam int unsigned    PLCR_BC_AN_RESTART   = 9;
    localparam int unsigned    PLCR_BC_FULL_DUPLEX  = 8;
    localparam int unsigned    PLCR_BC_ALT_XOVER    = 5;
    localparam int unsigned    PLCR_BC_FORCE_XOVER  = 4;
    localparam int unsigned    PLCR_BC_XOVER_OFF    = 3;
    localparam int unsigned    PLCR_BC_TX_DISABLE   = 1;

    // ============================================================
    // Same fields as seen in port2_control_four
    localparam int unsigned    PLCR_C4_ALT_XOVER    = 15;
    localparam int unsigned    PLCR_C4_TX_DISABLE   = 14;
    localparam int unsigned    PLCR_C4_AN_RESTART   = 13;
    localparam int unsigned    PLCR_C4_POWER_DOWN   = 11;
    localparam int unsigned    PLCR_C4_XOVER_OFF    = 10;
    localparam int unsigned    PLCR_C4_FORCE_XOVER  = 9;
    localparam int unsigned    PLCR_C4_LOOPBACK     = 8;
    localparam int unsigned    PLCR_C4_AN_ENABLE    = 7;
    localparam int unsigned    PLCR_C4_FORCE_100    = 6;
    localparam int unsigned    PLCR_C4_FULL_DUPLEX  = 5;

    // ============================================================
    // Control storage and its value after reset
    typedef struct packed {
        logic loopback;
        logic force_100;
        logic an_enable;
        logic power_down;
        logic an_restart;
        logic full_duplex;
        logic alt_xover;
        logic force_xover;
        logic xover_off;
        logic tx_disable;
    } plcr_ctrl_t;

    localparam plcr_ctrl_t     PLCR_CTRL_RESET      = '{loopback: 1'b0, force_100: 1'b1, an_enable: 1'b1,
                                                        power_down: 1'b0, an_restart: 1'b0, full_duplex: 1'b1,
                                                        alt_xover: 1'b1, force_xover: 1'b0, xover_off: 1'b0,
                                                        tx_disable: 1'b0};

    // Negotiation result reported by the PHY
    typedef struct packed {
        logic an_complete;
        logic an_failed;
        logic speed_100;
        logic full_duplex;
    } plcr_an_t;

    // Operating mode handed to the PHY
    typedef struct packed {
        logic loopback;
        logic speed_100;
        logic full_duplex;
        logic an_enable;
        logic an_restart;
        logic power_down;
        logic alt_xover;
        logic force_xover;
        logic xover_off;
        logic tx_disable;
    } plcr_phy_t;

    localparam plcr_phy_t      PLCR_PHY_RESET       = '{loopback: 1'b0, speed_100: 1'b1, full_duplex: 1'b1,
                                                        an_enable: 1'b1, an_restart: 1'b0, power_down: 1'b0,
                                                        alt_xover: 1'b1, force_xover: 1'b0, xover_off: 1'b0,
                                                        tx_disable: 1'b0};

endpackage

// ---- rtl/plcr_sync.sv ----
// Three-stage synchroniser that passes each bit once its last two stages agree
`timescale 1ns/1ps

module plcr_sync #(
    parameter int unsigned WIDTH = 5,
    parameter logic [WIDTH-1:0] RESET_VALUE = '0
) (
    // Clock and reset
    input  wire logic             clk,
    input  wire logic             rst_n,
    // Asynchronous word and its settled copy
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] stage1_r;
    logic [WIDTH-1:0] stage2_r;
    logic [WIDTH-1:0] stage3_r;

    initial begin
        if (WIDTH < 1) begin
            $error("plcr_sync: WIDTH must be at least 1");
        end
    end

    // ============================================================
    // Capture chain; stage1 feeds stage2 only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stage1_r <= RESET_VALUE;
            stage2_r <= RESET_VALUE;
            stage3_r <= RESET_VALUE;
        end else begin
            stage1_r <= async_in;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
        end
    end

    // ============================================================
    // Per bit: a change counts once two stages agree, hiding a one-cycle glitch
    for (genvar i = 0; i < WIDTH; i++) begin : g_agree
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                sync_out[i] <= RESET_VALUE[i];
            end else if (stage2_r[i] == stage3_r[i]) begin
                sync_out[i] <= stage3_r[i];
            end
        end
    end

endmodule

// ---- rtl/plcr_regs.sv ----
// Register view of the copper port PHYs: Port 1 partner ability and Port 2 basic control over APB
`timescale 1ns/1ps

module plcr_regs #(
    parameter int unsigned STATUS_W = 5
) (
    // Clock and reset
    input  wire logic                     REF_CLK,
    input  wire logic                     RSTN,
    // APB slave
    input  wire logic                     PSEL,
    input  wire logic                     PENABLE,
    input  wire logic                     PWRITE,
    input  wire logic [11:0]              PADDR,
    input  wire logic [31:0]              PWDATA,
    input  wire logic [3:0]               PSTRB,
    output logic                          PREADY,
    output logic      [31:0]              PRDATA,
    output logic                          PSLVERR,
    // Port 1 status from the PHY, asynchronous
    input  wire logic [STATUS_W-1:0]      P1_STATUS_IN,
    // Port 2 negotiation result from the PHY, asynchronous
    input  wire plcr_pkg::plcr_an_t       P2_AN_IN,
    // Writes into port2_control_four, same clock
    input  wire logic                     C4_WRITE,
    input  wire logic [15:0]              C4_WDATA,
    // Port 2 operating mode
    output plcr_pkg::plcr_phy_t           P2_PHY_CTRL,
    // Shared control bits as port2_control_four sees them
    output logic      [15:0]              C4_IMAGE
);

    import plcr_pkg::*;

    initial begin
        if (STATUS_W != 5) begin
            $error("plcr_regs: STATUS_W must be 5");
        end
    end

    // ============================================================
    // Layout checks; aliased or misaligned words would both answer one address
    initial begin
        if (PLCR_ADDR_PARTNER[1:0] != 2'b00 || PLCR_ADDR_CONTROL[1:0] != 2'b00) begin
            $error("plcr_regs: register addresses must be word aligned");
        end
        if (PLCR_ADDR_PARTNER == PLCR_ADDR_CONTROL) begin
            $error("plcr_regs: register addresses must differ");
        end
        if (PLCR_BC_LOOPBACK > 15 || PLCR_C4_ALT_XOVER > 15) begin
            $error("plcr_regs: field positions must fit a 16-bit word");
        end
    end

    // ============================================================
    // Declarations
    logic [STATUS_W-1:0] status_sync;
    plcr_an_t            an_sync;
    logic [STATUS_W-1:0] status_r;
    plcr_ctrl_t          ctrl_r;
    plcr_ctrl_t          ctrl_nxt;
    plcr_phy_t           phy_r;
    plcr_phy_t           phy_nxt;
    logic                restart_pulse_r;
    logic                pready_r;
    logic [31:0]         prdata_r;
    logic                pslverr_r;
    logic [15:0]         c4_image_r;
    logic                setup_phase;
    logic                access_done;
    logic                wr_control;
    logic                restart_req;
    logic [15:0]         wdata_merged;
    logic [1:0]          addr_hit;
    logic [15:0]         partner_word;
    logic [15:0]         control_word;

    // ============================================================
    // Decode used by both the read and the write path
    function automatic logic [1:0] plcr_decode(input logic [11:0] addr);
        logic [1:0] hit;
        hit = 2'b00;
        if (addr == PLCR_ADDR_PARTNER) begin
            hit[0] = 1'b1;
        end
        if (addr == PLCR_ADDR_CONTROL) begin
            hit[1] = 1'b1;
        end
        return hit;
    endfunction

    // Reserved bits read zero here; the self-clearing restart bit reads its stored value
    function automatic logic [15:0] plcr_control_word(input plcr_ctrl_t c);
        logic [15:0] w;
        w                      = 16'h0000;
        w[PLCR_BC_LOOPBACK]    = c.loopback;
        w[PLCR_BC_FORCE_100]   = c.force_100;
        w[PLCR_BC_AN_ENABLE]   = c.an_enable;
        w[PLCR_BC_POWER_DOWN]  = c.power_down;
        w[PLCR_BC_AN_RESTART]  = c.an_restart;
        w[PLCR_BC_FULL_DUPLEX] = c.full_duplex;
        w[PLCR_BC_ALT_XOVER]   = c.alt_xover;
        w[PLCR_BC_FORCE_XOVER] = c.force_xover;
        w[PLCR_BC_XOVER_OFF]   = c.xover_off;
        w[PLCR_BC_TX_DISABLE]  = c.tx_disable;
        return w;
    endfunction

    function automatic logic [15:0] plcr_partner_word(input logic [4:0] s);
        logic [15:0] w;
        w                 = 16'h0000;
        w[PLCR_PA_PAUSE]  = s[4];
        w[PLCR_PA_100FD]  = s[3];
        w[PLCR_PA_100HD]  = s[2];
        w[PLCR_PA_BIT6]   = s[1];
        w[PLCR_PA_10HD]   = s[0];
        w[4:0]            = PLCR_PA_LOW_VALUE;
        return w;
    endfunction

    // ============================================================
    // Input synchronisers
    plcr_sync #(
        .WIDTH       (STATUS_W),
        .RESET_VALUE (PLCR_STATUS_RESET)
    ) u_status_sync (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .async_in (P1_STATUS_IN),
        .sync_out (status_sync)
    );

    // Bits settle one by one, so a result changing mid-word may look mixed for a cycle
    plcr_sync #(
        .WIDTH       (4),
        .RESET_VALUE (4'h0)
    ) u_an_sync (
        .clk      (REF_CLK),
        .rst_n    (RSTN),
        .async_in (P2_AN_IN),
        .sync_out (an_sync)
    );

    // ============================================================
    // Partner ability mirror
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            status_r <= PLCR_STATUS_RESET;
        end else begin
            status_r <= status_sync;
        end
    end

    // ============================================================
    // Read images of both words
    assign partner_word = plcr_partner_word(status_r);
    assign control_word = plcr_control_word(ctrl_r);

    // ============================================================
    // APB handshake: one wait-free access phase per transfer
    assign addr_hit    = plcr_decode(PADDR);
    assign setup_phase = PSEL && !PENABLE;
    assign access_done = PSEL && PENABLE && pready_r;
    assign wr_control  = access_done && PWRITE && addr_hit[1];

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            pready_r <= 1'b0;
        end else begin
            pready_r <= setup_phase;
        end
    end

    // Read data and error are settled in the setup cycle so both come from flops
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end else if (setup_phase) begin
            unique case (addr_hit)
                2'b01: begin
                    prdata_r  <= PWRITE ? 32'h0000_0000 : {16'h0000, partner_word};
                    pslverr_r <= 1'b0;
                end
                2'b10: begin
                    prdata_r  <= PWRITE ? 32'h0000_0000 : {16'h0000, control_word};
                    pslverr_r <= 1'b0;
                end
                default: begin
                    prdata_r  <= 32'h0000_0000;
                    pslverr_r <= 1'b1;
                end
            endcase
        end else if (!PSEL) begin
            prdata_r  <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
    end

    // ============================================================
    // Control storage, shared with port2_control_four
    always_comb begin
        wdata_merged = plcr_control_word(ctrl_r);
        if (PSTRB[0]) begin
            wdata_merged[7:0] = PWDATA[7:0];
        end
        if (PSTRB[1]) begin
            wdata_merged[15:8] = PWDATA[15:8];
        end
    end

    // Restart request from either view; the set wins over the self-clear
    assign restart_req = (wr_control && wdata_merged[PLCR_BC_AN_RESTART])
                      || (C4_WRITE && C4_WDATA[PLCR_C4_AN_RESTART]);

    always_comb begin
        ctrl_nxt = ctrl_r;
        if (C4_WRITE) begin
            ctrl_nxt.loopback    = C4_WDATA[PLCR_C4_LOOPBACK];
            ctrl_nxt.force_100   = C4_WDATA[PLCR_C4_FORCE_100];
            ctrl_nxt.an_enable   = C4_WDATA[PLCR_C4_AN_ENABLE];
            ctrl_nxt.power_down  = C4_WDATA[PLCR_C4_POWER_DOWN];
            ctrl_nxt.full_duplex = C4_WDATA[PLCR_C4_FULL_DUPLEX];
            ctrl_nxt.alt_xover   = C4_WDATA[PLCR_C4_ALT_XOVER];
            ctrl_nxt.force_xover = C4_WDATA[PLCR_C4_FORCE_XOVER];
            ctrl_nxt.xover_off   = C4_WDATA[PLCR_C4_XOVER_OFF];
            ctrl_nxt.tx_disable  = C4_WDATA[PLCR_C4_TX_DISABLE];
        end
        // Loopback has no bus path: only the control-four view can set it
        // Bus write wins over a same-cycle write from the other view
        if (wr_control) begin
            ctrl_nxt.force_100   = wdata_merged[PLCR_BC_FORCE_100];
            ctrl_nxt.an_enable   = wdata_merged[PLCR_BC_AN_ENABLE];
            ctrl_nxt.power_down  = wdata_merged[PLCR_BC_POWER_DOWN];
            ctrl_nxt.full_duplex = wdata_merged[PLCR_BC_FULL_DUPLEX];
            ctrl_nxt.alt_xover   = wdata_merged[PLCR_BC_ALT_XOVER];
            ctrl_nxt.force_xover = wdata_merged[PLCR_BC_FORCE_XOVER];
            ctrl_nxt.xover_off   = wdata_merged[PLCR_BC_XOVER_OFF];
            ctrl_nxt.tx_disable  = wdata_merged[PLCR_BC_TX_DISABLE];
        end
        if (restart_req) begin
            ctrl_nxt.an_restart = 1'b1;
        end else if (restart_pulse_r) begin
            ctrl_nxt.an_restart = 1'b0;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= PLCR_CTRL_RESET;
        end else begin
            ctrl_r <= ctrl_nxt;
        end
    end

    // ============================================================
    // Restart pulse: one cycle per request, then the bit clears
    // A request landing on the pulse cycle keeps the bit and earns a second pulse
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            restart_pulse_r <= 1'b0;
        end else begin
            restart_pulse_r <= ctrl_r.an_restart && !restart_pulse_r;
        end
    end

    // ============================================================
    // Operating mode resolution
    // Negotiated values hold while a new negotiation runs, so the link sees no gap
    always_comb begin
        phy_nxt             = PLCR_PHY_RESET;
        phy_nxt.loopback    = ctrl_r.loopback;
        phy_nxt.an_enable   = ctrl_r.an_enable;
        phy_nxt.an_restart  = restart_pulse_r;
        phy_nxt.power_down  = ctrl_r.power_down;
        phy_nxt.alt_xover   = ctrl_r.alt_xover;
        phy_nxt.force_xover = ctrl_r.force_xover;
        phy_nxt.xover_off   = ctrl_r.xover_off;
        phy_nxt.tx_disable  = ctrl_r.tx_disable;
        if (!ctrl_r.an_enable) begin
            phy_nxt.speed_100   = ctrl_r.force_100;
            phy_nxt.full_duplex = ctrl_r.full_duplex;
        end else if (an_sync.an_failed) begin
            // Speed has no documented fallback, so the forced choice is reused
            phy_nxt.speed_100   = ctrl_r.force_100;
            phy_nxt.full_duplex = ctrl_r.full_duplex;
        end else if (an_sync.an_complete) begin
            phy_nxt.speed_100   = an_sync.speed_100;
            phy_nxt.full_duplex = an_sync.full_duplex;
        end else begin
            phy_nxt.speed_100   = phy_r.speed_100;
            phy_nxt.full_duplex = phy_r.full_duplex;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            phy_r <= PLCR_PHY_RESET;
        end else begin
            phy_r <= phy_nxt;
        end
    end

    // ============================================================
    // Image of the shared bits for the control-four view
    // Fed from the next value so both views change on the same edge; reset clears it to 0, so the first edge after reset moves it alone
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            c4_image_r <= 16'h0000;
        end else begin
            c4_image_r                      <= 16'h0000;
            c4_image_r[PLCR_C4_ALT_XOVER]   <= ctrl_nxt.alt_xover;
            c4_image_r[PLCR_C4_TX_DISABLE]  <= ctrl_nxt.tx_disable;
            c4_image_r[PLCR_C4_AN_RESTART]  <= ctrl_nxt.an_restart;
            c4_image_r[PLCR_C4_POWER_DOWN]  <= ctrl_nxt.power_down;
            c4_image_r[PLCR_C4_XOVER_OFF]   <= ctrl_nxt.xover_off;
            c4_image_r[PLCR_C4_FORCE_XOVER] <= ctrl_nxt.force_xover;
            c4_image_r[PLCR_C4_LOOPBACK]    <= ctrl_nxt.loopback;
            c4_image_r[PLCR_C4_AN_ENABLE]   <= ctrl_nxt.an_enable;
            c4_image_r[PLCR_C4_FORCE_100]   <= ctrl_nxt.force_100;
            c4_image_r[PLCR_C4_FULL_DUPLEX] <= ctrl_nxt.full_duplex;
        end
    end

    // ============================================================
    // Outputs
    assign PREADY      = pready_r;
    assign PRDATA      = prdata_r;
    assign PSLVERR     = pslverr_r;
    assign P2_PHY_CTRL = phy_r;
    assign C4_IMAGE    = c4_image_r;

endmodule

// ---- bench/plcr_regs_properties.sv ----
// Concurrent checks on the ports of the PHY link register view
`timescale 1ns/1ps
module plcr_regs_properties
    import plcr_pkg::*;
#(
    parameter int unsigned STATUS_W = 5
) (
    // Clock and reset
    input wire logic                REF_CLK,
    input wire logic                RSTN,
    // APB slave
    input wire logic                PSEL,
    input wire logic                PENABLE,
    input wire logic                PWRITE,
    input wire logic [11:0]         PADDR,
    input wire logic [31:0]         PWDATA,
    input wire logic [3:0]          PSTRB,
    input wire logic                PREADY,
    input wire logic [31:0]         PRDATA,
    input wire logic                PSLVERR,
    // PHY side
    input wire logic [STATUS_W-1:0] P1_STATUS_IN,
    input wire plcr_pkg::plcr_an_t  P2_AN_IN,
    input wire logic                C4_WRITE,
    input wire logic [15:0]         C4_WDATA,
    input wire plcr_pkg::plcr_phy_t P2_PHY_CTRL,
    input wire logic [15:0]         C4_IMAGE
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);
    logic setup;
    logic mapped;
    assign setup = PSEL && !PENABLE;
    assign mapped = (PADDR == PLCR_ADDR_PARTNER) || (PADDR == PLCR_ADDR_CONTROL);

    AST_PARTNER_FIXED: assert property (setup && !PWRITE && PADDR == PLCR_ADDR_PARTNER
        |=> PREADY && PRDATA[4:0] == 5'h01 && PRDATA[31:11] == 21'h0 && !PRDATA[9]) else $error("partner fixed bits");
    AST_CTRL_RSVD: assert property (setup && !PWRITE && PADDR == PLCR_ADDR_CONTROL
        |=> PREADY && (PRDATA & 32'hffff84c5) == 32'h0) else $error("control reserved bits");
    AST_UNMAPPED: assert property (setup && !mapped |=> PREADY && PSLVERR) else $error("no error");
    AST_MAPPED_OK: assert property (setup && mapped |=> PREADY && !PSLVERR) else $error("bad answer");
    AST_RESTART_ISSUE: assert property (PSEL && PENABLE && PREADY && PWRITE && PADDR == PLCR_ADDR_CONTROL
        && PSTRB[1] && PWDATA[9] |-> ##[2:3] P2_PHY_CTRL.an_restart) else $error("restart not issued");
    AST_RESTART_PULSE: assert property (P2_PHY_CTRL.an_restart |=> !P2_PHY_CTRL.an_restart)
        else $error("restart pulse too long");
    // Three quiet cycles let the mode register catch up with the control word
    AST_FORCED_MODE: assert property ((!C4_IMAGE[7] && $stable(C4_IMAGE))[*3]
        |-> P2_PHY_CTRL.speed_100 == C4_IMAGE[6] && P2_PHY_CTRL.full_duplex == C4_IMAGE[5]) else $error("forced mode");
    AST_MIRROR_A: assert property ($stable(C4_IMAGE)[*3]
        |-> P2_PHY_CTRL.loopback == C4_IMAGE[8] && P2_PHY_CTRL.an_enable == C4_IMAGE[7]) else $error("mirror a");
    AST_MIRROR_B: assert property ($stable(C4_IMAGE)[*3]
        |-> P2_PHY_CTRL.alt_xover == C4_IMAGE[15] && P2_PHY_CTRL.tx_disable == C4_IMAGE[14]
        && P2_PHY_CTRL.power_down == C4_IMAGE[11] && P2_PHY_CTRL.xover_off == C4_IMAGE[10]
        && P2_PHY_CTRL.force_xover == C4_IMAGE[9]) else $error("mirror b");
endmodule

// ---- bench/plcr_phy_model.sv ----
// Behavioural PHY: partner status and negotiation outcome
`timescale 1ns/1ps
module plcr_phy_model
    import plcr_pkg::*;
#(
    parameter int unsigned AN_CYCLES = 6
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rst_n,
    // Scenario controls
    input  wire logic [4:0] partner_caps,
    input  wire logic       an_fail,
    input  wire logic       an_speed,
    input  wire logic       an_fdx,
    // Register view side
    input  wire plcr_phy_t  phy_ctrl,
    output logic [4:0]      status,
    output plcr_an_t        an_res
);
    int cnt;
    assign status = partner_caps;
    // Result is withdrawn during negotiation so the view must hold its old mode
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt <= 0;
            an_res <= '0;
        end else if (phy_ctrl.an_restart) begin
            cnt <= AN_CYCLES;
            an_res <= '0;
        end else if (cnt == 1) begin
            cnt <= 0;
            an_res <= '{an_complete: !an_fail, an_failed: an_fail, speed_100: an_speed, full_duplex: an_fdx};
        end else if (cnt != 0) begin
            cnt <= cnt - 1;
        end
    end
endmodule

// ---- bench/phy_link_control_regs_bench.sv ----
// Self-checking bench for the PHY link register view
`timescale 1ns/1ps
module phy_link_control_regs_bench;
    import plcr_pkg::*;
    logic        clk;
    logic        rst_n;
    logic        psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic [4:0]  caps, p1_status;
    logic        an_fail, c4_write;
    logic [15:0] c4_wdata, c4_image;
    plcr_an_t    an_res;
    plcr_phy_t   phy;
    int          n_mismatch;
    int          num_checks;

    plcr_regs #(.STATUS_W(5)) DUT (.REF_CLK(clk), .RSTN(rst_n), .PSEL(psel), .PENABLE(penable),
        .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata),
        .PSLVERR(pslverr), .P1_STATUS_IN(p1_status), .P2_AN_IN(an_res), .C4_WRITE(c4_write),
        .C4_WDATA(c4_wdata), .P2_PHY_CTRL(phy), .C4_IMAGE(c4_image));
    plcr_phy_model u_phy (.clk(clk), .rst_n(rst_n), .partner_caps(caps), .an_fail(an_fail),
        .an_speed(1'b0), .an_fdx(1'b1), .phy_ctrl(phy), .status(p1_status), .an_res(an_res));

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Waits for the answer however long it takes; only the watchdog ends a hang
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        repeat (3) @(posedge clk);
    endtask

    task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask

    task automatic c4(input logic [15:0] v);
        c4_wdata <= v;
        c4_write <= 1'b1;
        @(posedge clk);
        c4_write <= 1'b0;
        repeat (4) @(posedge clk);
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    initial begin
        #(40 * 4000);
        n_mismatch++;
        results();
    end

    initial begin
        rst_n <= 1'b0;
        {psel, penable, pwrite, c4_write, an_fail} <= '0;
        paddr <= '0;
        pwdata <= '0;
        pstrb <= 4'hf;
        caps <= '0;
        c4_wdata <= '0;
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (8) @(posedge clk);
        rdchk(PLCR_ADDR_PARTNER, 32'h0001);
        rdchk(PLCR_ADDR_CONTROL, 32'h3120);
        chk(32'(c4_image), 32'h80e0);
        caps <= 5'h15;
        repeat (8) @(posedge clk);
        rdchk(PLCR_ADDR_PARTNER, 32'h04a1);
        caps <= 5'h0a;
        apb(1'b1, PLCR_ADDR_PARTNER, 32'hffff);
        rdchk(PLCR_ADDR_PARTNER, 32'h0141);
        apb(1'b1, PLCR_ADDR_CONTROL, 32'hffff);
        rdchk(PLCR_ADDR_CONTROL, 32'h393a);
        chk(32'(c4_image), 32'hcee0);
        chk(32'({phy.power_down, phy.force_xover, phy.tx_disable, phy.xover_off}), 32'hf);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, PLCR_ADDR_CONTROL, {18'h0, i[1], 4'h0, i[0], 8'h00});
            rdchk(PLCR_ADDR_CONTROL, {18'h0, i[1], 4'h0, i[0], 8'h00});
            chk(32'({phy.speed_100, phy.full_duplex}), 32'(i[1:0]));
        end
        pstrb <= 4'h1;
        apb(1'b1, PLCR_ADDR_CONTROL, 32'hffff);
        rdchk(PLCR_ADDR_CONTROL, 32'h213a);
        pstrb <= 4'hf;
        c4(16'h0100);
        rdchk(PLCR_ADDR_CONTROL, 32'h4000);
        chk(32'(phy.loopback), 32'h1);
        apb(1'b1, PLCR_ADDR_CONTROL, 32'h0000);
        rdchk(PLCR_ADDR_CONTROL, 32'h4000);
        c4(16'h0000);
        // Duplex bit kept clear while negotiating
        apb(1'b1, PLCR_ADDR_CONTROL, 32'h1200);
        repeat (16) @(posedge clk);
        rdchk(PLCR_ADDR_CONTROL, 32'h1000);
        chk(32'({phy.speed_100, phy.full_duplex}), 32'h1);
        chk(32'(phy.an_enable), 32'h1);
        an_fail <= 1'b1;
        apb(1'b1, PLCR_ADDR_CONTROL, 32'h3200);
        repeat (16) @(posedge clk);
        chk(32'({phy.speed_100, phy.full_duplex}), 32'h2);
        apb(1'b0, 12'h164, 32'h0);
        chk(32'(err), 32'h1);
        results();
    end
endmodule

bind plcr_regs plcr_regs_properties #(.STATUS_W(STATUS_W)) u_props (.REF_CLK(REF_CLK), .RSTN(RSTN),
    .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(PSTRB),
    .PREADY(PREADY), .PRDATA(PRDATA), .PSLVERR(PSLVERR), .P1_STATUS_IN(P1_STATUS_IN), .P2_AN_IN(P2_AN_IN),
    .C4_WRITE(C4_WRITE), .C4_WDATA(C4_WDATA), .P2_PHY_CTRL(P2_PHY_CTRL), .C4_IMAGE(C4_IMAGE));
